// ---- common/usb_event_defines.svh ----
// Offsets, bit positions and reset values of the USB event flag block
`ifndef USB_EVENT_DEFINES_SVH
`define USB_EVENT_DEFINES_SVH
`define EVT_FLAGS_ADDR 8'hbd
`define EVT_ENABLE_ADDR 8'hbe
`define BIT_WAKE 5
`define BIT_RESET_END 4
`define BIT_FRAME 3
`define BIT_SUSPEND 0
`define EVT_FLAGS_MASK 8'h39
`define EVT_FLAGS_RESET 8'h00
`define EVT_ENABLE_RESET 8'h10
`endif

// ---- common/usb_event_pkg.sv ----
// Types shared by the USB event flag block
package usb_event_pkg;
	typedef struct packed {
		logic wake;
		logic reset_end;
		logic frame;
		logic suspend;
	} evt_vec_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;
endpackage : usb_event_pkg

// ---- core/usb_event_flag_bit.sv ----
// One sticky event flag with write-zero clear, set over clear
module usb_event_flag_bit
(
	// System
	input wire logic clk_sys,
	input wire logic rstn,
	// Control
	input wire logic set_pulse,
	input wire logic clr_pulse,
	// State
	output logic flag_q
);
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			flag_q <= 1'b0;
		else if (set_pulse)
			flag_q <= 1'b1;
		else if (clr_pulse)
			flag_q <= 1'b0;
	end
endmodule : usb_event_flag_bit

// ---- core/usb_global_event_flags.sv ----
// Global USB event flag register with enables and shared interrupt
`include "usb_event_defines.svh"
module usb_global_event_flags
	import usb_event_pkg::*;
(
	// System
	input wire logic clk_sys,
	input wire logic rstn,
	// Events from the protocol engine; bus_suspended and upstream_resume are levels, the rest one-cycle pulses
	input wire logic line_active,
	input wire logic bus_suspended,
	input wire logic upstream_resume,
	input wire logic reset_end_evt,
	input wire logic frame_start_evt,
	input wire logic suspend_evt,
	// Special-function register port
	input wire sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	// Interrupt and flag view
	output logic usb_irq,
	output evt_vec_t usb_event_flags
);
	evt_vec_t set_v;
	evt_vec_t clr_v;
	evt_vec_t en_q;
	logic flags_wr;
	logic en_wr;
	logic [7:0] flags_rd;
	logic [7:0] en_rd;
	localparam logic [7:0] en_reset_val = `EVT_ENABLE_RESET;

	assign flags_wr = sfr_req.wr && sfr_req.addr == `EVT_FLAGS_ADDR;
	assign en_wr = sfr_req.wr && sfr_req.addr == `EVT_ENABLE_ADDR;

	// Own upstream resume never counts as wake
	assign set_v.wake = bus_suspended && line_active && !upstream_resume;
	assign set_v.reset_end = reset_end_evt;
	assign set_v.frame = frame_start_evt;
	assign set_v.suspend = suspend_evt;

	// Writing zero to a flag bit clears it; writing one leaves it
	assign clr_v.wake = flags_wr && !sfr_req.wdata[`BIT_WAKE];
	assign clr_v.reset_end = flags_wr && !sfr_req.wdata[`BIT_RESET_END];
	assign clr_v.frame = flags_wr && !sfr_req.wdata[`BIT_FRAME];
	assign clr_v.suspend = flags_wr && !sfr_req.wdata[`BIT_SUSPEND];

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_flag
			usb_event_flag_bit u_flag
			(
				.clk_sys(clk_sys),
				.rstn(rstn),
				.set_pulse(set_v[gi]),
				.clr_pulse(clr_v[gi]),
				.flag_q(usb_event_flags[gi])
			);
		end
	endgenerate

	// Enable register
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			en_q.wake <= en_reset_val[`BIT_WAKE];
			en_q.reset_end <= en_reset_val[`BIT_RESET_END];
			en_q.frame <= en_reset_val[`BIT_FRAME];
			en_q.suspend <= en_reset_val[`BIT_SUSPEND];
		end
		else if (en_wr)
		begin
			en_q.wake <= sfr_req.wdata[`BIT_WAKE];
			en_q.reset_end <= sfr_req.wdata[`BIT_RESET_END];
			en_q.frame <= sfr_req.wdata[`BIT_FRAME];
			en_q.suspend <= sfr_req.wdata[`BIT_SUSPEND];
		end
	end

	assign usb_irq = |(usb_event_flags & en_q);

	// Reserved positions always zero
	always_comb
	begin
		flags_rd = 8'h00;
		flags_rd[`BIT_WAKE] = usb_event_flags.wake;
		flags_rd[`BIT_RESET_END] = usb_event_flags.reset_end;
		flags_rd[`BIT_FRAME] = usb_event_flags.frame;
		flags_rd[`BIT_SUSPEND] = usb_event_flags.suspend;
		en_rd = 8'h00;
		en_rd[`BIT_WAKE] = en_q.wake;
		en_rd[`BIT_RESET_END] = en_q.reset_end;
		en_rd[`BIT_FRAME] = en_q.frame;
		en_rd[`BIT_SUSPEND] = en_q.suspend;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			sfr_rdata <= 8'h00;
		else if (sfr_req.rd && sfr_req.addr == `EVT_FLAGS_ADDR)
			sfr_rdata <= flags_rd;
		else if (sfr_req.rd && sfr_req.addr == `EVT_ENABLE_ADDR)
			sfr_rdata <= en_rd;
		else
			sfr_rdata <= 8'h00;
	end

	// Flags follow their events
	a_wake_set: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		set_v.wake |=> usb_event_flags.wake)
		else $error("wake flag not set");

	a_wake_own_resume: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		!usb_event_flags.wake && upstream_resume && !flags_wr
		|=> !usb_event_flags.wake)
		else $error("wake flag set by own resume");

	a_no_wake_awake: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		!bus_suspended && !usb_event_flags.wake
		|=> !usb_event_flags.wake)
		else $error("wake flag set while not suspended");

	a_reset_end_set: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		reset_end_evt |=> usb_event_flags.reset_end)
		else $error("reset end flag not set");

	a_frame_set: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		frame_start_evt |=> usb_event_flags.frame)
		else $error("frame flag not set");

	a_suspend_set: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		suspend_evt |=> usb_event_flags.suspend)
		else $error("suspend flag not set");

	// Interrupt gating
	a_irq_wake: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		usb_event_flags.wake && en_q.wake |-> usb_irq)
		else $error("wake interrupt missing");

	a_irq_reset_end: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		usb_event_flags.reset_end && en_q.reset_end |-> usb_irq)
		else $error("reset end interrupt missing");

	a_irq_frame: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		usb_event_flags.frame && en_q.frame |-> usb_irq)
		else $error("frame interrupt missing");

	a_irq_suspend: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		usb_event_flags.suspend && en_q.suspend |-> usb_irq)
		else $error("suspend interrupt missing");

	a_irq_quiet: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(usb_event_flags & en_q) == 4'h0 |-> !usb_irq)
		else $error("spurious interrupt");

	a_enable_write: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		en_wr |=> en_q == {$past(sfr_req.wdata[`BIT_WAKE]),
		$past(sfr_req.wdata[`BIT_RESET_END]),
		$past(sfr_req.wdata[`BIT_FRAME]),
		$past(sfr_req.wdata[`BIT_SUSPEND])})
		else $error("enable write lost");

	// Clearing and holding
	a_flag_hold: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		!flags_wr |=> usb_event_flags >= $past(usb_event_flags) &&
		(usb_event_flags & $past(usb_event_flags)) == $past(usb_event_flags))
		else $error("flag lost without write");

	a_clear_on_write: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(clr_v & ~set_v) != 4'h0 |=>
		(usb_event_flags & $past(clr_v & ~set_v)) == 4'h0)
		else $error("flag not cleared by write");

	a_set_over_clear: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(set_v & clr_v) != 4'h0 |=>
		(usb_event_flags & $past(set_v & clr_v)) == $past(set_v & clr_v))
		else $error("clear beat a set");

	// Read path
	a_reserved_zero: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(sfr_rdata & ~`EVT_FLAGS_MASK) == 8'h00)
		else $error("reserved bit reads one");

	a_read_flags: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		sfr_req.rd && sfr_req.addr == `EVT_FLAGS_ADDR |=>
		sfr_rdata == {2'b00, $past(usb_event_flags.wake),
		$past(usb_event_flags.reset_end), $past(usb_event_flags.frame),
		2'b00, $past(usb_event_flags.suspend)})
		else $error("flag read mismatch");

	// Scenarios worth seeing

	c_wake_irq: cover property (@(posedge clk_sys) disable iff (!rstn)
		set_v.wake && en_q.wake ##1 usb_irq);
	c_frame_clear: cover property (@(posedge clk_sys) disable iff (!rstn)
		usb_event_flags.frame ##1 clr_v.frame ##1 !usb_event_flags.frame);
	c_set_and_clear: cover property (@(posedge clk_sys) disable iff (!rstn)
		suspend_evt && clr_v.suspend);
	c_suspend_irq: cover property (@(posedge clk_sys) disable iff (!rstn)
		suspend_evt && en_q.suspend ##1 usb_irq);
	c_own_resume: cover property (@(posedge clk_sys) disable iff (!rstn)
		bus_suspended && line_active && upstream_resume);
endmodule : usb_global_event_flags

// ---- verif/usb_evt_engine_model.sv ----
// Protocol engine model that reports bus events
module usb_evt_engine_model
(
	// System
	input wire logic clk_sys,
	// Events
	output logic line_active,
	output logic bus_suspended,
	output logic upstream_resume,
	output logic reset_end_evt,
	output logic frame_start_evt,
	output logic suspend_evt
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		{line_active, bus_suspended, upstream_resume} = 3'h0;
		{reset_end_evt, frame_start_evt, suspend_evt} = 3'h0;
	end
	// One-cycle event: 0 wake, 1 reset end, 2 frame, 3 suspend
	task automatic fire(input logic [1:0] k);
		@(posedge clk_sys);
		line_active <= (k == 2'h0);
		reset_end_evt <= (k == 2'h1);
		frame_start_evt <= (k == 2'h2);
		suspend_evt <= (k == 2'h3);
		@(posedge clk_sys);
		{line_active, reset_end_evt, frame_start_evt, suspend_evt} <= 4'h0;
	endtask : fire
	// Bus levels, changed at a rising edge
	task automatic levels(input logic susp, input logic own_resume);
		@(posedge clk_sys);
		bus_suspended <= susp;
		upstream_resume <= own_resume;
	endtask : levels
endmodule : usb_evt_engine_model

// ---- verif/usb_global_event_flags_tb_top.sv ----
// Bench for the USB event flag register
`include "usb_event_defines.svh"
module usb_global_event_flags_tb_top
	import usb_event_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, rstn, irq, la, bs, ur, re, fs, se;
	sfr_req_t req;
	logic [7:0] rdata, b, c;
	evt_vec_t flags;
	int err_count = 0;
	int n_tests = 0;
	int pos [4] = '{5, 4, 3, 0};
	usb_global_event_flags usb_global_event_flags_i
	(
		.clk_sys(clk_sys), .rstn(rstn), .line_active(la),
		.bus_suspended(bs), .upstream_resume(ur), .reset_end_evt(re),
		.frame_start_evt(fs), .suspend_evt(se), .sfr_req(req),
		.sfr_rdata(rdata), .usb_irq(irq), .usb_event_flags(flags)
	);
	usb_evt_engine_model usb_evt_engine_model_i
	(
		.clk_sys(clk_sys), .line_active(la), .bus_suspended(bs),
		.upstream_resume(ur), .reset_end_evt(re),
		.frame_start_evt(fs), .suspend_evt(se)
	);
	task automatic chk(input string nm, input logic [7:0] got, exp);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %s exp %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] a, d);
		@(posedge clk_sys);
		req <= '{w, !w, a, d};
		@(posedge clk_sys);
		req <= '0;
		#1;
	endtask : acc
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial
	begin
		repeat (3000) @(posedge clk_sys);
		err_count++;
		close_out();
	end
	initial
	begin
		rstn = 1'b0;
		req = '0;
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		acc(0, `EVT_FLAGS_ADDR, 0);
		chk("flags", rdata, 0);
		chk("irq", irq, 0);
		acc(0, `EVT_ENABLE_ADDR, 0);
		chk("enable", rdata, `EVT_ENABLE_RESET);
		acc(1, `EVT_ENABLE_ADDR, `EVT_FLAGS_MASK);
		usb_evt_engine_model_i.levels(1'b1, 1'b0);
		for (int k = 0; k < 4; k++)
		begin
			b = 8'h01 << pos[k];
			c = `EVT_FLAGS_MASK & ~b;
			usb_evt_engine_model_i.fire(k[1:0]);
			#1;
			chk("irq", irq, 1);
			acc(1, `EVT_FLAGS_ADDR, `EVT_FLAGS_MASK);
			acc(0, `EVT_FLAGS_ADDR, 0);
			chk("flags", rdata, b);
			chk("view", flags, {b[5:3], b[0]});
			// USB clocks run throughout, so clearing wake is allowed
			acc(1, `EVT_FLAGS_ADDR, c);
			chk("irq", irq, 0);
		end
		$display("event tests done");
		acc(1, `EVT_ENABLE_ADDR, 8'h00);
		usb_evt_engine_model_i.fire(2'h2);
		#1;
		chk("irq", irq, 0);
		acc(1, `EVT_ENABLE_ADDR, 8'h08);
		chk("irq", irq, 1);
		acc(1, `EVT_FLAGS_ADDR, `EVT_FLAGS_MASK & ~8'h08);
		chk("irq", irq, 0);
		usb_evt_engine_model_i.levels(1'b1, 1'b1);
		usb_evt_engine_model_i.fire(2'h0);
		usb_evt_engine_model_i.levels(1'b0, 1'b0);
		usb_evt_engine_model_i.fire(2'h0);
		acc(0, `EVT_FLAGS_ADDR, 0);
		chk("flags", rdata, 0);
		acc(0, 8'hbf, 0);
		chk("unmapped", rdata, 0);
		$display("mask and wake tests done");
		// Event and clearing write land on one edge
		fork
			usb_evt_engine_model_i.fire(2'h3);
			acc(1, `EVT_FLAGS_ADDR, 8'h00);
		join
		acc(0, `EVT_FLAGS_ADDR, 0);
		chk("set wins", rdata, 8'h01);
		$display("set over clear test done");
		usb_evt_engine_model_i.fire(2'h1);
		#1;
		chk("view", flags, 8'h05);
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		#1;
		chk("view", flags, 0);
		chk("irq", irq, 0);
		acc(0, `EVT_ENABLE_ADDR, 0);
		chk("enable", rdata, `EVT_ENABLE_RESET);
		acc(0, `EVT_FLAGS_ADDR, 0);
		chk("flags", rdata, 0);
		$display("mid-run reset test done");
		close_out();
	end
endmodule : usb_global_event_flags_tb_top
